// file: dv/tx_symbol_serializer_monitor.sv
`timescale 1ns/1ps
module tx_symbol_serializer_monitor (
    input wire logic       i_clk,
    input wire logic       i_rst_b,
    input wire logic [7:0] i_sfr_addr,
    input wire logic       i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic       i_serializer_enable,
    input wire logic       i_modulation_select,
    input wire logic [1:0] i_run_out_control,
    input wire logic [2:0] i_group_width,
    input wire logic [2:0] i_serializer_clock_divide,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic       o_data_empty,
    input wire logic       o_write_notify,
    input wire logic       o_symbol,
    input wire logic       o_lc_oscillator_on,
    input wire logic       o_divider_on,
    input wire logic       o_amplifier_on,
    input wire logic [6:0] o_deviation_value
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    logic wr_byte;
    assign wr_byte = i_sfr_wr && (i_sfr_addr == tx_serializer_pkg::ADDR_INPUT_BYTE);
    // ==========================================================
    // Register side
    a_empty_clear_cause: assert property ($fell(o_data_empty) |-> $past(wr_byte))
        else $error("empty flag cleared without a byte write");
    a_notify_after_write: assert property (wr_byte |=> o_write_notify)
        else $error("no notify after byte write");
    a_notify_has_write: assert property (o_write_notify |-> $past(wr_byte))
        else $error("notify without a byte write");
    a_rate_high_top: assert property ($past(i_sfr_addr) == tx_serializer_pkg::ADDR_RATE_HIGH
        |-> o_sfr_rdata[7] == 1'b0)
        else $error("rate high bit 7 reads one");
    a_osc_warm_top: assert property ($past(i_sfr_addr) == tx_serializer_pkg::ADDR_WARM_OSC
        |-> o_sfr_rdata[7:4] == 4'h0)
        else $error("oscillator warm upper bits read nonzero");
    // ==========================================================
    // Output side
    a_deviation_fsk_only: assert property (o_deviation_value != 7'h00
        |-> $past(i_modulation_select))
        else $error("deviation driven outside FSK");
    a_symbol_biased: assert property (o_symbol
        |-> o_lc_oscillator_on && o_divider_on && o_amplifier_on)
        else $error("one symbol sent without full bias");
    a_divider_order: assert property ($rose(o_divider_on) |-> o_lc_oscillator_on)
        else $error("divider biased before oscillator");
    a_amplifier_order: assert property ($rose(o_amplifier_on) |-> o_divider_on)
        else $error("amplifier biased before divider");
    c_notify: cover property (wr_byte ##1 o_write_notify);
    c_symbol: cover property ($rose(o_symbol));
    c_deviation: cover property (o_deviation_value != 7'h00);
    c_shutdown: cover property ($fell(o_amplifier_on));
endmodule : tx_symbol_serializer_monitor

bind tx_symbol_serializer tx_symbol_serializer_monitor mon (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
    .i_sfr_wdata(i_sfr_wdata), .i_serializer_enable(i_serializer_enable),
    .i_modulation_select(i_modulation_select), .i_run_out_control(i_run_out_control),
    .i_group_width(i_group_width), .i_serializer_clock_divide(i_serializer_clock_divide),
    .o_sfr_rdata(o_sfr_rdata), .o_data_empty(o_data_empty), .o_write_notify(o_write_notify),
    .o_symbol(o_symbol), .o_lc_oscillator_on(o_lc_oscillator_on), .o_divider_on(o_divider_on),
    .o_amplifier_on(o_amplifier_on), .o_deviation_value(o_deviation_value));

// file: dv/tx_symbol_serializer_tb.sv
`timescale 1ns/1ps
module tx_symbol_serializer_tb;
    typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rdata;} row_t;
    logic       i_clk = 1'b0;
    logic       i_rst_b = 1'b0;
    logic [7:0] i_sfr_addr = 8'h00;
    logic       i_sfr_wr = 1'b0;
    logic [7:0] i_sfr_wdata = 8'h00;
    logic       i_serializer_enable = 1'b0;
    logic       i_modulation_select = 1'b1;
    logic [1:0] i_run_out_control = 2'h0;
    logic [2:0] i_group_width = 3'h7;
    logic [2:0] i_serializer_clock_divide = 3'h1;
    logic [7:0] o_sfr_rdata;
    logic       o_data_empty;
    logic       o_write_notify;
    logic       o_symbol;
    logic       o_lc_oscillator_on;
    logic       o_divider_on;
    logic       o_amplifier_on;
    logic [6:0] o_deviation_value;
    int         bad_count = 0;
    int         checks = 0;
    int         n_osc;
    int         n_div;
    int         n_pa;
    int         n;
    logic [7:0] pat = 8'hCD;
    row_t       rows [6];

    tx_symbol_serializer dut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
        .i_sfr_wdata(i_sfr_wdata), .i_serializer_enable(i_serializer_enable),
        .i_modulation_select(i_modulation_select), .i_run_out_control(i_run_out_control),
        .i_group_width(i_group_width), .i_serializer_clock_divide(i_serializer_clock_divide),
        .o_sfr_rdata(o_sfr_rdata), .o_data_empty(o_data_empty), .o_write_notify(o_write_notify),
        .o_symbol(o_symbol), .o_lc_oscillator_on(o_lc_oscillator_on), .o_divider_on(o_divider_on),
        .o_amplifier_on(o_amplifier_on), .o_deviation_value(o_deviation_value));

    always #50 i_clk = ~i_clk;

    // ==========================================================
    // Tasks
    task automatic results();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_sfr_addr = a;
        i_sfr_wdata = d;
        i_sfr_wr = 1'b1;
        @(negedge i_clk);
        i_sfr_wr = 1'b0;
        @(negedge i_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_sfr_addr = a;
        @(negedge i_clk);
        check("rdata", o_sfr_rdata, e);
    endtask : rd

    // Bias phases are tallied while waiting, so warm-up lengths come for free
    task automatic wait_sym(input logic lvl);
        int k;
        k = 0;
        while (o_symbol !== lvl)
        begin
            if (o_amplifier_on === 1'b1) n_pa++;
            else if (o_divider_on === 1'b1) n_div++;
            else if (o_lc_oscillator_on === 1'b1) n_osc++;
            k++;
            if (k > 600)
            begin
                bad_count++;
                $display("mismatch symbol_wait expected %b seen timeout", lvl);
                results();
            end
            @(negedge i_clk);
        end
    endtask : wait_sym

    // ==========================================================
    // Sequence
    initial
    begin
        rows = '{'{8'hAC, 8'hFF, 8'hFF}, '{8'hAD, 8'hFF, 8'h7F}, '{8'hAE, 8'hA5, 8'hA5},
                 '{8'hAF, 8'hFF, 8'h0F}, '{8'hE4, 8'h7F, 8'h7F}, '{8'hA0, 8'hFF, 8'h00}};
        repeat (12) @(negedge i_clk);
        i_rst_b = 1'b1;
        check("empty", 8'(o_data_empty), 8'h01);
        rd(tx_serializer_pkg::ADDR_INPUT_BYTE, 8'h00);
        foreach (rows[i]) rd(rows[i].addr, 8'h00);
        foreach (rows[i])
        begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, rows[i].rdata);
        end
        // Byte write while idle: one notify, empty cleared
        i_sfr_addr = tx_serializer_pkg::ADDR_INPUT_BYTE;
        i_sfr_wdata = 8'h2D;
        i_sfr_wr = 1'b1;
        @(negedge i_clk);
        i_sfr_wr = 1'b0;
        check("notify", 8'(o_write_notify), 8'h01);
        check("empty", 8'(o_data_empty), 8'h00);
        @(negedge i_clk);
        check("notify", 8'(o_write_notify), 8'h00);
        // FSK, divisor 3, clock divide 2: six clocks a symbol
        wr(tx_serializer_pkg::ADDR_RATE_LOW, 8'h03);
        wr(tx_serializer_pkg::ADDR_RATE_HIGH, 8'h00);
        wr(tx_serializer_pkg::ADDR_WARM_DA, 8'h12);
        wr(tx_serializer_pkg::ADDR_WARM_OSC, 8'hF1);
        wr(tx_serializer_pkg::ADDR_DEVIATION, 8'h5A);
        wr(tx_serializer_pkg::ADDR_INPUT_BYTE, pat);
        n_osc = 0;
        n_div = 0;
        n_pa = 0;
        i_serializer_enable = 1'b1;
        wait_sym(1'b1);
        check("osc_warm", 8'(n_osc >= 127 && n_osc <= 131), 8'h01);
        check("div_warm", 8'(n_div >= 8 && n_div <= 11), 8'h01);
        check("pa_warm", 8'(n_pa >= 4 && n_pa <= 7), 8'h01);
        n = 0;
        while (o_symbol === 1'b1 && n < 20)
        begin
            if (n == 2) check("deviation", 8'(o_deviation_value), 8'h5A);
            n++;
            @(negedge i_clk);
        end
        check("hold", 8'(n), 8'h06);
        repeat (3) @(negedge i_clk);
        for (int i = 1; i < 8; i++)
        begin
            check("symbol", 8'(o_symbol), 8'(pat[i]));
            repeat (6) @(negedge i_clk);
        end
        repeat (6) @(negedge i_clk);
        check("pa_off", 8'(o_amplifier_on), 8'h00);
        check("empty", 8'(o_data_empty), 8'h01);
        // OOK: a zero drops bias, the next one re-warms
        i_modulation_select = 1'b0;
        i_group_width = 3'h2;
        wr(tx_serializer_pkg::ADDR_INPUT_BYTE, 8'h05);
        wait_sym(1'b1);
        @(negedge i_clk);
        check("ook_dev", 8'(o_deviation_value), 8'h00);
        wait_sym(1'b0);
        repeat (3) @(negedge i_clk);
        check("ook_zero_pa", 8'(o_amplifier_on), 8'h00);
        n_osc = 0;
        wait_sym(1'b1);
        check("rewarm", 8'(n_osc >= 127), 8'h01);
        // Run-out modes after a two-symbol group of 0 then 1
        i_modulation_select = 1'b1;
        i_group_width = 3'h1;
        for (int m = 1; m < 4; m++)
        begin
            i_serializer_enable = 1'b0;
            i_run_out_control = 2'(m);
            repeat (3) @(negedge i_clk);
            i_serializer_enable = 1'b1;
            wr(tx_serializer_pkg::ADDR_INPUT_BYTE, 8'h02);
            wait_sym(1'b1);
            repeat (9) @(negedge i_clk);
            check("run_out_a", 8'(o_symbol), 8'(m == 3));
            repeat (6) @(negedge i_clk);
            check("run_out_b", 8'(o_symbol), 8'(m != 2));
        end
        // Reset in mid-run: outputs and registers back to reset values
        i_rst_b = 1'b0;
        @(negedge i_clk);
        check("rst_symbol", 8'(o_symbol), 8'h00);
        check("rst_pa", 8'(o_amplifier_on), 8'h00);
        check("rst_empty", 8'(o_data_empty), 8'h01);
        i_rst_b = 1'b1;
        rd(tx_serializer_pkg::ADDR_RATE_LOW, 8'h00);
        check("rst_notify", 8'(o_write_notify), 8'h00);
        results();
    end
endmodule : tx_symbol_serializer_tb

// file: hw/serializer_clock_divider.sv
`timescale 1ns/1ps
module serializer_clock_divider #(
    parameter int DIV_WIDTH = 3
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_b,
    input  wire logic                 i_run,
    input  wire logic [DIV_WIDTH-1:0] i_divide,
    output logic                      o_tick
);

    logic [DIV_WIDTH-1:0] count;

    // ==========================================================
    // One tick every divide+1 system clocks
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            count <= '0;
        end
        else if (!i_run || count == i_divide)
        begin
            count <= '0;
        end
        else
        begin
            count <= count + 1'b1;
        end
    end

    assign o_tick = i_run && (count == i_divide);

endmodule : serializer_clock_divider

// file: hw/tx_serializer_pkg.sv
// How it works
// - Writing the input byte register clears the data-empty flag, unless the held byte is consumed in that same cycle.
// - Each input byte write gives one registered pulse after data is held.
// - Symbols leave the holding register least significant bit first.
// - Rate divisor is 15 bits; low eight from the rate-low register.
// - Rate divisor upper seven bits come from rate-high bits 6 to 0.
// - Symbol rate is system clock over divisor times clock division factor.
// - Rate-high bit 7 and oscillator warm-up bits 7:4 read zero.
// - Warm oscillator, divider and amplifier before sending and on OOK zero-to-one.
// - Divider warm-up lasts field value times four serializer clocks.
// - Amplifier warm-up lasts field value serializer clocks.
// - Oscillator warm-up lasts field value times 64 serializer clocks.
// - Deviation_value comes from bits 6 to 0 of the deviation register.
// - Serializer clock is system clock divided by divide field plus one.
// - Modulation select zero means on-off keying, one means FSK.
// - On data run-out: shut down, repeat group, send zeros or ones.
// - Group width field sets one to eight symbols sent per group.
package tx_serializer_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADDR_INPUT_BYTE = 8'hAB;
    localparam logic [7:0] ADDR_RATE_LOW   = 8'hAC;
    localparam logic [7:0] ADDR_RATE_HIGH  = 8'hAD;
    localparam logic [7:0] ADDR_WARM_DA    = 8'hAE;
    localparam logic [7:0] ADDR_WARM_OSC   = 8'hAF;
    localparam logic [7:0] ADDR_DEVIATION  = 8'hE4;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_INPUT_BYTE = 8'h00;
    localparam logic [7:0] RST_RATE_LOW   = 8'h00;
    localparam logic [6:0] RST_RATE_HIGH  = 7'h00;
    localparam logic [7:0] RST_WARM_DA    = 8'h00;
    localparam logic [3:0] RST_WARM_OSC   = 4'h0;
    localparam logic [7:0] RST_DEVIATION  = 8'h00;

    // ==========================================================
    // Field layout and timing scales
    localparam int RATE_WIDTH       = 15;
    localparam int RATE_HIGH_MSB    = 6;
    localparam int DIV_WARM_LSB     = 4;
    localparam int PA_WARM_LSB      = 0;
    localparam int OSC_WARM_LSB     = 0;
    localparam int DEVIATION_MSB    = 6;
    localparam int WARM_CNT_WIDTH   = 12;
    localparam int DIV_WARM_SCALE   = 4;
    localparam int OSC_WARM_SCALE   = 64;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        RUN_OUT_SHUTDOWN = 2'h0,
        RUN_OUT_REPEAT   = 2'h1,
        RUN_OUT_ZEROS    = 2'h2,
        RUN_OUT_ONES     = 2'h3
    } run_out_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WARM = 2'b01,
        ST_SEND = 2'b11
    } state_t;

    typedef enum logic [1:0] {
        PH_OSC = 2'b00,
        PH_DIV = 2'b01,
        PH_PA  = 2'b11
    } warm_phase_t;

    // Serializer clock cycles of one warm-up phase
    function automatic logic [WARM_CNT_WIDTH-1:0] warm_cycles(
        input warm_phase_t phase,
        input logic [3:0]  osc_field,
        input logic [3:0]  div_field,
        input logic [3:0]  pa_field
    );
        logic [WARM_CNT_WIDTH-1:0] cycles;
        cycles = '0;
        unique case (phase)
            PH_OSC: cycles = WARM_CNT_WIDTH'(osc_field) * WARM_CNT_WIDTH'(OSC_WARM_SCALE);
            PH_DIV: cycles = WARM_CNT_WIDTH'(div_field) * WARM_CNT_WIDTH'(DIV_WARM_SCALE);
            PH_PA:  cycles = WARM_CNT_WIDTH'(pa_field);
            default: cycles = '0;
        endcase
        return cycles;
    endfunction : warm_cycles

endpackage : tx_serializer_pkg

// file: hw/tx_symbol_serializer.sv
`timescale 1ns/1ps
module tx_symbol_serializer (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic [7:0] i_sfr_addr,
    input  wire logic       i_sfr_wr,
    input  wire logic [7:0] i_sfr_wdata,
    input  wire logic       i_serializer_enable,
    input  wire logic       i_modulation_select,
    input  wire logic [1:0] i_run_out_control,
    input  wire logic [2:0] i_group_width,
    input  wire logic [2:0] i_serializer_clock_divide,
    output logic [7:0]      o_sfr_rdata,
    output logic            o_data_empty,
    output logic            o_write_notify,
    output logic            o_symbol,
    output logic            o_lc_oscillator_on,
    output logic            o_divider_on,
    output logic            o_amplifier_on,
    output logic [6:0]      o_deviation_value
);

    // ==========================================================
    // Register file
    logic [7:0] serializer_input_byte;
    logic [7:0] symbol_rate_low;
    logic [6:0] symbol_rate_high;
    logic [7:0] warmup_divider_amplifier;
    logic [3:0] warmup_oscillator;
    logic [7:0] frequency_deviation;

    logic       write_notify;
    logic       pending;
    logic       data_empty;

    tx_serializer_pkg::state_t      state;
    tx_serializer_pkg::warm_phase_t phase;
    logic [tx_serializer_pkg::WARM_CNT_WIDTH-1:0] warm_cnt;
    logic [tx_serializer_pkg::RATE_WIDTH-1:0]     rate_cnt;
    logic [tx_serializer_pkg::RATE_WIDTH-1:0]     divisor;
    logic [7:0] shift;
    logic [7:0] last_group;
    logic [2:0] bit_idx;
    logic       tick;
    logic       symbol_end;
    logic       warm_done;
    logic       load_start;

    logic       sel_byte;
    logic       shut_down;
    logic [7:0] next_shift;
    logic [2:0] next_bit_idx;
    logic       next_take_pending;

    wire logic bus_wr_byte = i_sfr_wr && (i_sfr_addr == tx_serializer_pkg::ADDR_INPUT_BYTE);

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            serializer_input_byte    <= tx_serializer_pkg::RST_INPUT_BYTE;
            symbol_rate_low          <= tx_serializer_pkg::RST_RATE_LOW;
            symbol_rate_high         <= tx_serializer_pkg::RST_RATE_HIGH;
            warmup_divider_amplifier <= tx_serializer_pkg::RST_WARM_DA;
            warmup_oscillator        <= tx_serializer_pkg::RST_WARM_OSC;
            frequency_deviation      <= tx_serializer_pkg::RST_DEVIATION;
        end
        else if (i_sfr_wr)
        begin
            unique case (i_sfr_addr)
                tx_serializer_pkg::ADDR_INPUT_BYTE: serializer_input_byte <= i_sfr_wdata;
                tx_serializer_pkg::ADDR_RATE_LOW:   symbol_rate_low       <= i_sfr_wdata;
                tx_serializer_pkg::ADDR_RATE_HIGH:
                    symbol_rate_high <= i_sfr_wdata[tx_serializer_pkg::RATE_HIGH_MSB:0];
                tx_serializer_pkg::ADDR_WARM_DA:    warmup_divider_amplifier <= i_sfr_wdata;
                tx_serializer_pkg::ADDR_WARM_OSC:   warmup_oscillator <= i_sfr_wdata[3:0];
                // Bit 7 is stored as written; software keeps it clear
                tx_serializer_pkg::ADDR_DEVIATION:  frequency_deviation <= i_sfr_wdata;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Read-back, registered; unmapped offsets read zero
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_sfr_rdata <= 8'h00;
        end
        else
        begin
            unique case (i_sfr_addr)
                tx_serializer_pkg::ADDR_INPUT_BYTE: o_sfr_rdata <= serializer_input_byte;
                tx_serializer_pkg::ADDR_RATE_LOW:   o_sfr_rdata <= symbol_rate_low;
                tx_serializer_pkg::ADDR_RATE_HIGH:  o_sfr_rdata <= {1'b0, symbol_rate_high};
                tx_serializer_pkg::ADDR_WARM_DA:    o_sfr_rdata <= warmup_divider_amplifier;
                tx_serializer_pkg::ADDR_WARM_OSC:   o_sfr_rdata <= {4'h0, warmup_oscillator};
                tx_serializer_pkg::ADDR_DEVIATION:  o_sfr_rdata <= frequency_deviation;
                default:                            o_sfr_rdata <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Write notification and handshake flags
    // Pulse follows the write by one edge, so the byte is already held
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            write_notify <= 1'b0;
        else
            write_notify <= bus_wr_byte;
    end

    assign o_write_notify = write_notify;

    // Consumption of the held byte sets empty; the set wins over a clear
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            data_empty <= 1'b1;
        else if (sel_byte)
            data_empty <= 1'b1;
        else if (bus_wr_byte)
            data_empty <= 1'b0;
    end

    assign o_data_empty = data_empty;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            pending <= 1'b0;
        else if (write_notify)
            pending <= 1'b1;
        else if (sel_byte)
            pending <= 1'b0;
    end

    // ==========================================================
    // Timing
    serializer_clock_divider #(
        .DIV_WIDTH (3)
    ) u_clock_divider (
        .i_clk    (i_clk),
        .i_rst_b  (i_rst_b),
        // Restarted as warm-up ends, so the first symbol gets a full period
        .i_run    (i_serializer_enable && !warm_done),
        .i_divide (i_serializer_clock_divide),
        .o_tick   (tick)
    );

    assign divisor = {symbol_rate_high, symbol_rate_low};

    // A zero divisor behaves as one, never a stalled symbol
    assign symbol_end = (state == tx_serializer_pkg::ST_SEND) && tick
                        && (rate_cnt + 1'b1 >= divisor);

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            rate_cnt <= '0;
        else if (state != tx_serializer_pkg::ST_SEND || symbol_end)
            rate_cnt <= '0;
        else if (tick)
            rate_cnt <= rate_cnt + 1'b1;
    end

    // ==========================================================
    // Next symbol group selection
    always_comb
    begin
        next_take_pending = 1'b0;
        shut_down         = 1'b0;
        next_shift        = {1'b0, shift[7:1]};
        next_bit_idx      = bit_idx + 1'b1;
        if (bit_idx >= i_group_width)
        begin
            next_bit_idx = 3'h0;
            if (pending)
            begin
                next_take_pending = 1'b1;
                next_shift        = serializer_input_byte;
            end
            else
            begin
                unique case (tx_serializer_pkg::run_out_t'(i_run_out_control))
                    tx_serializer_pkg::RUN_OUT_SHUTDOWN: shut_down  = 1'b1;
                    tx_serializer_pkg::RUN_OUT_REPEAT:   next_shift = last_group;
                    tx_serializer_pkg::RUN_OUT_ZEROS:    next_shift = 8'h00;
                    tx_serializer_pkg::RUN_OUT_ONES:     next_shift = 8'hFF;
                endcase
            end
        end
    end

    assign load_start = (state == tx_serializer_pkg::ST_IDLE) && i_serializer_enable && pending;
    assign sel_byte   = load_start || (symbol_end && next_take_pending);
    assign warm_done  = (state == tx_serializer_pkg::ST_WARM)
                        && (phase == tx_serializer_pkg::PH_PA) && (warm_cnt == '0);

    // ==========================================================
    // Sequencer
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            state <= tx_serializer_pkg::ST_IDLE;
        else if (!i_serializer_enable)
            state <= tx_serializer_pkg::ST_IDLE;
        else
        begin
            unique case (state)
                tx_serializer_pkg::ST_IDLE:
                    if (load_start)
                        state <= tx_serializer_pkg::ST_WARM;
                tx_serializer_pkg::ST_WARM:
                    if (warm_done)
                        state <= tx_serializer_pkg::ST_SEND;
                tx_serializer_pkg::ST_SEND:
                    if (symbol_end && shut_down)
                    begin
                        state <= tx_serializer_pkg::ST_IDLE;
                    end
                    else if (symbol_end && !i_modulation_select && !shift[0] && next_shift[0])
                    begin
                        state <= tx_serializer_pkg::ST_WARM;
                    end
                default: state <= tx_serializer_pkg::ST_IDLE;
            endcase
        end
    end

    // Phases run oscillator, divider, amplifier, each from its own count
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            phase    <= tx_serializer_pkg::PH_OSC;
            warm_cnt <= '0;
        end
        else if (state != tx_serializer_pkg::ST_WARM)
        begin
            phase    <= tx_serializer_pkg::PH_OSC;
            warm_cnt <= tx_serializer_pkg::warm_cycles(tx_serializer_pkg::PH_OSC,
                            warmup_oscillator, warmup_divider_amplifier[7:4],
                            warmup_divider_amplifier[3:0]);
        end
        else if (warm_cnt == '0)
        begin
            if (phase == tx_serializer_pkg::PH_OSC)
            begin
                phase    <= tx_serializer_pkg::PH_DIV;
                warm_cnt <= tx_serializer_pkg::warm_cycles(tx_serializer_pkg::PH_DIV,
                                warmup_oscillator, warmup_divider_amplifier[7:4],
                                warmup_divider_amplifier[3:0]);
            end
            else if (phase == tx_serializer_pkg::PH_DIV)
            begin
                phase    <= tx_serializer_pkg::PH_PA;
                warm_cnt <= tx_serializer_pkg::warm_cycles(tx_serializer_pkg::PH_PA,
                                warmup_oscillator, warmup_divider_amplifier[7:4],
                                warmup_divider_amplifier[3:0]);
            end
        end
        else if (tick)
        begin
            warm_cnt <= warm_cnt - 1'b1;
        end
    end

    // ==========================================================
    // Shift register
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            shift      <= 8'h00;
            last_group <= 8'h00;
            bit_idx    <= 3'h0;
        end
        else if (load_start)
        begin
            shift      <= serializer_input_byte;
            last_group <= serializer_input_byte;
            bit_idx    <= 3'h0;
        end
        else if (symbol_end)
        begin
            shift   <= next_shift;
            bit_idx <= next_bit_idx;
            if (next_take_pending)
            begin
                last_group <= serializer_input_byte;
            end
        end
    end

    // ==========================================================
    // Outputs to the transmit chain
    // Off-keyed zeros drop all three bias lines to save power
    wire logic sending = (state == tx_serializer_pkg::ST_SEND)
                         && (i_modulation_select || shift[0]);
    wire logic warming = (state == tx_serializer_pkg::ST_WARM);

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_symbol           <= 1'b0;
            o_lc_oscillator_on <= 1'b0;
            o_divider_on       <= 1'b0;
            o_amplifier_on     <= 1'b0;
            o_deviation_value  <= 7'h00;
        end
        else
        begin
            o_symbol           <= (state == tx_serializer_pkg::ST_SEND) && shift[0];
            o_lc_oscillator_on <= warming || sending;
            o_divider_on       <= (warming && phase != tx_serializer_pkg::PH_OSC)
                                  || sending;
            o_amplifier_on     <= (warming && phase == tx_serializer_pkg::PH_PA)
                                  || sending;
            if ((state == tx_serializer_pkg::ST_SEND) && i_modulation_select && shift[0])
            begin
                o_deviation_value <= frequency_deviation[tx_serializer_pkg::DEVIATION_MSB:0];
            end
            else
            begin
                o_deviation_value <= 7'h00;
            end
        end
    end

endmodule : tx_symbol_serializer
